//--- pkg/env_sensor_map.svh
`ifndef ENV_SENSOR_MAP_SVH
`define ENV_SENSOR_MAP_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define MEAS_STATUS_ADDR    8'h1d
`define PRESS_HIGH_ADDR     8'h1f
`define PRESS_MID_ADDR      8'h20
`define PRESS_LOW_ADDR      8'h21
`define TEMP_HIGH_ADDR      8'h22
`define TEMP_MID_ADDR       8'h23
`define TEMP_LOW_ADDR       8'h24
`define HUM_HIGH_ADDR       8'h25
`define HUM_LOW_ADDR        8'h26
`define GAS_HIGH_ADDR       8'h2a
`define GAS_LOW_ADDR        8'h2b
`define GAS_CTRL_ADDR       8'h71

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define NEW_DATA_BIT        7
`define GAS_MEASURING_BIT   6
`define MEASURING_BIT       5
`define GAS_VALID_BIT       5
`define HEAT_STAB_BIT       4
`define RUN_GAS_BIT         4

// ---------------------------------------------------------------
// Limits, reset values and shadow width
// ---------------------------------------------------------------
`define MAX_PROFILE         4'h9
`define RESULT_RESET        8'h00
`define PROFILE_RESET       4'h0
`define SHADOW_WIDTH        84

`endif

//--- pkg/env_sensor_pkg.sv
package env_sensor_pkg;

    // Register byte and address types
    typedef logic [7:0]  reg_byte_t;
    typedef logic [7:0]  reg_addr_t;

    // Raw result and setting types
    typedef logic [19:0] raw20_t;
    typedef logic [15:0] raw16_t;
    typedef logic [9:0]  raw10_t;
    typedef logic [3:0]  nibble_t;
    typedef logic [2:0]  osrs_t;

endpackage

//--- src/busy_flag.sv
`timescale 1ns/100ps

module busy_flag (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    // Activity and transfer events
    input  wire logic active_in,
    input  wire logic done_in,
    // Flag
    output logic      flag_out
);

    // ---------------------------------------------------------------
    // Flag storage
    // ---------------------------------------------------------------
    logic flag_reg;   // Current flag
    logic flag_next;  // Next flag

    // Held while running, dropped at transfer
    assign flag_next = active_in | (flag_reg & ~done_in);
    assign flag_out  = flag_reg;

    // Flag register
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

endmodule

//--- src/result_shadow.sv
`timescale 1ns/100ps

module result_shadow #(
    parameter int WIDTH = 84
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    // Live side
    input  wire logic             load_in,
    input  wire logic [WIDTH-1:0] data_in,
    // Read side
    input  wire logic             hold_in,
    output logic      [WIDTH-1:0] data_out
);

    // ---------------------------------------------------------------
    // Live and shadow copies
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] live_reg;    // Latest results
    logic [WIDTH-1:0] shadow_reg;  // Copy seen by reads

    assign data_out = shadow_reg;

    // Live copy takes results at end of cycle
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            live_reg <= '0;
        end else if (load_in) begin
            live_reg <= data_in;
        end
    end

    // Shadow frozen during a read burst
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            shadow_reg <= '0;
        end else if (!hold_in) begin
            shadow_reg <= live_reg;
        end
    end

endmodule

//--- src/env_sensor_result_status_regs.sv
// Operation
// (R1) Pressure split high, mid, upper nibble
// (R2) Temperature split high, mid, upper nibble
// (R3) Low nibble masked by oversampling resolution
// (R4) Humidity split high then low byte
// (R5) Gas resistance bits 9:2, then 1:0
// (R6) Gas range code in low bits
// (R7) Cycle end stores results, sets new-data
// (R8) Gas-measuring high only during gas conversion; code holds it until transfer
// (R9) Host leaves heater configuration alone while measuring
// (R10) Measuring high during any conversion
// (R11) Up to ten conversions, index 0-9
// (R12) Every cycle has a gas slot
// (R13) Gas-valid only for real conversions
// (R14) Heater stability bit in gas low byte
// (R15) Results shadowed against read overlap
// (R16) Profile selector picks set-point 0-9
// (R17) Result and status bytes are read-only
`timescale 1ns/100ps
`include "env_sensor_map.svh"

module env_sensor_result_status_regs (
    // Clock and reset
    input  wire logic                      clk_in,
    input  wire logic                      sys_rst_in,
    // Measurement engine: results at cycle end
    input  wire logic                      cycle_done_in,
    input  wire env_sensor_pkg::raw20_t    press_raw_in,
    input  wire env_sensor_pkg::raw20_t    temp_raw_in,
    input  wire env_sensor_pkg::raw16_t    hum_raw_in,
    input  wire env_sensor_pkg::raw10_t    gas_raw_in,
    input  wire env_sensor_pkg::nibble_t   gas_range_in,
    input  wire logic                      gas_real_in,
    input  wire logic                      heat_stable_in,
    input  wire env_sensor_pkg::nibble_t   gas_index_in,
    // Measurement engine: activity levels
    input  wire logic                      conv_active_in,
    input  wire logic                      gas_active_in,
    // Oversampling settings
    input  wire env_sensor_pkg::osrs_t     osrs_press_in,
    input  wire env_sensor_pkg::osrs_t     osrs_temp_in,
    // Host register port
    input  wire logic                      read_burst_in,
    input  wire logic                      rd_en_in,
    input  wire env_sensor_pkg::reg_addr_t rd_addr_in,
    input  wire logic                      wr_en_in,
    input  wire env_sensor_pkg::reg_addr_t wr_addr_in,
    input  wire env_sensor_pkg::reg_byte_t wr_data_in,
    output env_sensor_pkg::reg_byte_t      rd_data_out,
    output logic                           rd_valid_out,
    // Gas control to the engine
    output env_sensor_pkg::nibble_t        heater_profile_select_out,
    output logic                           run_gas_out,
    // Status to the engine
    output logic                           measuring_out,
    output logic                           new_data_out
);

    import env_sensor_pkg::*;

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------

    // Meaningful low-nibble bits for an oversampling code
    function automatic nibble_t xlsb_mask(input osrs_t osrs);
        nibble_t m;
        m = 4'h0;
        case (osrs)
            3'h0, 3'h1: m = 4'h0;  // 16 bits
            3'h2:       m = 4'h8;  // 17 bits
            3'h3:       m = 4'hc;  // 18 bits
            3'h4:       m = 4'he;  // 19 bits
            default:    m = 4'hf;  // 20 bits
        endcase
        return m;
    endfunction

    // Clamp a conversion number to the last set-point
    function automatic nibble_t clamp_index(input nibble_t idx);
        return (idx > `MAX_PROFILE) ? `MAX_PROFILE : idx;
    endfunction

    // ---------------------------------------------------------------
    // Result assembly
    // ---------------------------------------------------------------
    nibble_t          press_low_nib;   // Pressure bits 3:0 masked
    nibble_t          temp_low_nib;    // Temperature bits 3:0 masked
    reg_byte_t        press_hi_b;      // Pressure high byte
    reg_byte_t        press_mid_b;     // Pressure mid byte
    reg_byte_t        press_lo_b;      // Pressure low nibble byte
    reg_byte_t        temp_hi_b;       // Temperature high byte
    reg_byte_t        temp_mid_b;      // Temperature mid byte
    reg_byte_t        temp_lo_b;       // Temperature low nibble byte
    reg_byte_t        hum_hi_b;        // Humidity high byte
    reg_byte_t        hum_lo_b;        // Humidity low byte
    reg_byte_t        gas_hi_b;        // Gas resistance high byte
    reg_byte_t        gas_lo_b;        // Gas low bits and flags
    logic             gas_valid_bit;   // Real conversion marker
    nibble_t          index_live;      // Clamped conversion index
    logic             run_gas_reg;     // Gas conversions enabled
    logic [`SHADOW_WIDTH-1:0] live_vec;   // Packed live results
    logic [`SHADOW_WIDTH-1:0] shadow_vec; // Packed shadow results

    // (R3) resolution mask applied
    assign press_low_nib = press_raw_in[3:0] & xlsb_mask(osrs_press_in);
    assign temp_low_nib  = temp_raw_in[3:0] & xlsb_mask(osrs_temp_in);

    // (R1) pressure byte split
    assign press_hi_b  = press_raw_in[19:12];
    assign press_mid_b = press_raw_in[11:4];
    assign press_lo_b  = {press_low_nib, 4'h0};

    // (R2) temperature byte split
    assign temp_hi_b  = temp_raw_in[19:12];
    assign temp_mid_b = temp_raw_in[11:4];
    assign temp_lo_b  = {temp_low_nib, 4'h0};

    // (R4) humidity byte split
    assign hum_hi_b = hum_raw_in[15:8];
    assign hum_lo_b = hum_raw_in[7:0];

    // Gas disabled turns every slot into a dummy
    // (R12) dummy slot when gas disabled
    // (R13) valid only for real conversion
    assign gas_valid_bit = gas_real_in & run_gas_reg;

    // (R5) gas resistance split
    assign gas_hi_b = gas_raw_in[9:2];

    // (R6) range code low bits
    // (R14) heater stability bit
    assign gas_lo_b = {gas_raw_in[1:0], gas_valid_bit,
                       heat_stable_in, gas_range_in};

    // Out-of-range indices would name a missing set-point
    // (R11) index limited to 0-9
    assign index_live = clamp_index(gas_index_in);

    // Index travels with the results it describes
    // Packed in read order, index in the low nibble
    assign live_vec = {press_hi_b, press_mid_b, press_lo_b,
                       temp_hi_b, temp_mid_b, temp_lo_b,
                       hum_hi_b, hum_lo_b,
                       gas_hi_b, gas_lo_b, index_live};

    // ---------------------------------------------------------------
    // Result storage and shadow
    // ---------------------------------------------------------------

    // Reads see the shadow, never the live copy
    // (R7) results stored at cycle end
    // (R15) shadow held during read burst
    result_shadow #(
        .WIDTH    (`SHADOW_WIDTH)
    ) u_shadow (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .load_in    (cycle_done_in),
        .data_in    (live_vec),
        .hold_in    (read_burst_in),
        .data_out   (shadow_vec)
    );

    // ---------------------------------------------------------------
    // Status flags
    // ---------------------------------------------------------------
    logic measuring_flag;   // Any conversion running
    logic gas_meas_flag;    // Gas conversion running
    logic new_data_reg;     // New results waiting
    logic new_data_next;    // Next new-data value
    logic status_read;      // Host reads status byte

    // (R10) measuring until transfer
    busy_flag u_measuring (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .active_in  (conv_active_in),
        .done_in    (cycle_done_in),
        .flag_out   (measuring_flag)
    );

    // (R8) gas measuring until transfer
    busy_flag u_gas_measuring (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .active_in  (gas_active_in),
        .done_in    (cycle_done_in),
        .flag_out   (gas_meas_flag)
    );

    // Only a read of the status byte itself counts
    // Status byte read ends a new-data period
    assign status_read = rd_en_in & (rd_addr_in == `MEAS_STATUS_ADDR);

    // Status read returns the value before the clear
    // (R7) new-data set, set beats clear
    assign new_data_next = cycle_done_in | (new_data_reg & ~status_read);

    // New-data register
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            new_data_reg <= 1'b0;
        end else begin
            new_data_reg <= new_data_next;
        end
    end

    // ---------------------------------------------------------------
    // Gas control register
    // ---------------------------------------------------------------
    nibble_t profile_reg;    // Selected heater set-point
    nibble_t profile_next;   // Next set-point
    logic    run_gas_next;   // Next enable
    logic    ctrl_write;     // Host writes gas control

    // Only the gas control byte accepts writes
    assign ctrl_write = wr_en_in & (wr_addr_in == `GAS_CTRL_ADDR);

    // (R16) selector limited to 0-9
    assign profile_next = ctrl_write ? clamp_index(wr_data_in[3:0])
                                     : profile_reg;
    assign run_gas_next = ctrl_write ? wr_data_in[`RUN_GAS_BIT]
                                     : run_gas_reg;

    // Gas control registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            profile_reg <= `PROFILE_RESET;
            run_gas_reg <= 1'b0;
        end else begin
            profile_reg <= profile_next;
            run_gas_reg <= run_gas_next;
        end
    end

    // ---------------------------------------------------------------
    // Read decode
    // ---------------------------------------------------------------
    reg_byte_t status_b;   // Status byte image
    reg_byte_t ctrl_b;     // Gas control byte image
    reg_byte_t rd_mux;     // Selected byte

    // Status: new-data, gas busy, busy, index
    assign status_b = {new_data_reg, gas_meas_flag, measuring_flag,
                       1'b0, shadow_vec[3:0]};
    // Gas control reads back as stored, clamped
    assign ctrl_b   = {3'h0, run_gas_reg, profile_reg};

    // (R17) results only readable, unmapped reads zero
    assign rd_mux =
        (rd_addr_in == `MEAS_STATUS_ADDR) ? status_b :
        (rd_addr_in == `PRESS_HIGH_ADDR)  ? shadow_vec[83:76] :
        (rd_addr_in == `PRESS_MID_ADDR)   ? shadow_vec[75:68] :
        (rd_addr_in == `PRESS_LOW_ADDR)   ? shadow_vec[67:60] :
        (rd_addr_in == `TEMP_HIGH_ADDR)   ? shadow_vec[59:52] :
        (rd_addr_in == `TEMP_MID_ADDR)    ? shadow_vec[51:44] :
        (rd_addr_in == `TEMP_LOW_ADDR)    ? shadow_vec[43:36] :
        (rd_addr_in == `HUM_HIGH_ADDR)    ? shadow_vec[35:28] :
        (rd_addr_in == `HUM_LOW_ADDR)     ? shadow_vec[27:20] :
        (rd_addr_in == `GAS_HIGH_ADDR)    ? shadow_vec[19:12] :
        (rd_addr_in == `GAS_LOW_ADDR)     ? shadow_vec[11:4]  :
        (rd_addr_in == `GAS_CTRL_ADDR)    ? ctrl_b :
                                            `RESULT_RESET;

    // ---------------------------------------------------------------
    // Output registers
    // ---------------------------------------------------------------
    reg_byte_t rd_data_reg;    // Read data
    logic      rd_valid_reg;   // Read answer strobe
    logic      measuring_reg;  // Busy copy to engine
    logic      new_data_oreg;  // New-data copy

    // Read data holds between reads for a slow host
    // Read answer one cycle after request
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rd_data_reg  <= `RESULT_RESET;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_data_reg  <= rd_en_in ? rd_mux : rd_data_reg;
            rd_valid_reg <= rd_en_in;
        end
    end

    // Status copies for the engine
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            measuring_reg <= 1'b0;
            new_data_oreg <= 1'b0;
        end else begin
            measuring_reg <= measuring_flag;
            new_data_oreg <= new_data_reg;
        end
    end

    // Port drive
    assign rd_data_out               = rd_data_reg;
    assign rd_valid_out              = rd_valid_reg;
    assign heater_profile_select_out = profile_reg;
    assign run_gas_out               = run_gas_reg;
    assign measuring_out             = measuring_reg;
    assign new_data_out              = new_data_oreg;

endmodule

//--- testbench/host_port_model.sv
`timescale 1ns/100ps

// Host side of the register port, driven on the falling edge
module host_port_model (
    // Clock and device answers
    input  wire logic                      clk_in,
    input  wire logic                      measuring_in,
    input  wire logic                      rd_valid_in,
    input  wire env_sensor_pkg::reg_byte_t rd_data_in,
    // Requests to the device
    output logic                           rd_en_out,
    output env_sensor_pkg::reg_addr_t      rd_addr_out,
    output logic                           wr_en_out,
    output env_sensor_pkg::reg_addr_t      wr_addr_out,
    output env_sensor_pkg::reg_byte_t      wr_data_out,
    output logic                           burst_out
);
    import env_sensor_pkg::*;

    // Idle port at time zero
    initial begin
        rd_en_out = 1'b0;
        rd_addr_out = 8'h00;
        wr_en_out = 1'b0;
        wr_addr_out = 8'h00;
        wr_data_out = 8'h00;
        burst_out = 1'b0;
    end

    // One-cycle read; released lines show the inverse
    task automatic read_reg(input reg_addr_t a, output reg_byte_t d);
        int n;
        n = 0;
        rd_addr_out = a;
        rd_en_out = 1'b1;
        @(negedge clk_in);
        rd_en_out = 1'b0;
        rd_addr_out = ~a;
        while (rd_valid_in !== 1'b1 && n < 4) begin
            @(negedge clk_in);
            n++;
        end
        d = (rd_valid_in === 1'b1) ? rd_data_in : 8'hxx;
        // Let an edge pass before the next request
        @(negedge clk_in);
    endtask

    // One-cycle write, held off while converting
    task automatic write_reg(input reg_addr_t a, input reg_byte_t d);
        int n;
        n = 0;
        while (measuring_in === 1'b1 && n < 50) begin
            @(negedge clk_in);
            n++;
        end
        wr_addr_out = a;
        wr_data_out = d;
        wr_en_out = 1'b1;
        @(negedge clk_in);
        wr_en_out = 1'b0;
        wr_addr_out = ~a;
        wr_data_out = ~d;
        // Let an edge pass before the next request
        @(negedge clk_in);
    endtask

    // Serial read in progress marker
    task automatic set_burst(input logic b);
        burst_out = b;
        @(negedge clk_in);
    endtask
endmodule

//--- testbench/env_sensor_result_status_regs_properties.sv
`timescale 1ns/100ps

module result_regs_checker (
    input wire logic                      clk_in,
    input wire logic                      sys_rst_in,
    input wire logic                      cycle_done_in,
    input wire logic                      conv_active_in,
    input wire logic                      rd_en_in,
    input wire logic                      wr_en_in,
    input wire env_sensor_pkg::reg_addr_t wr_addr_in,
    input wire env_sensor_pkg::reg_byte_t wr_data_in,
    input wire env_sensor_pkg::reg_byte_t rd_data_out,
    input wire logic                      rd_valid_out,
    input wire env_sensor_pkg::nibble_t   heater_profile_select_out,
    input wire logic                      run_gas_out,
    input wire logic                      measuring_out,
    input wire logic                      new_data_out
);
    import env_sensor_pkg::*;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    // Write to the gas control byte and its clamped profile
    wire logic    cfg_wr_w = wr_en_in && (wr_addr_in == 8'h71);
    wire nibble_t clamp_w  = (wr_data_in[3:0] > 4'h9) ? 4'h9
                                                       : wr_data_in[3:0];

    rd_answer_a: assert property (rd_en_in |=> rd_valid_out)
        else $error("read not answered");
    meas_set_a: assert property (
        conv_active_in |-> ##2 measuring_out)
        else $error("measuring flag missing");
    meas_clear_a: assert property (
        cycle_done_in && !conv_active_in |-> ##2 !measuring_out)
        else $error("measuring flag stuck");
    new_data_set_a: assert property (
        cycle_done_in |-> ##2 new_data_out)
        else $error("new data flag missing");
    profile_clamp_a: assert property (
        cfg_wr_w |=> heater_profile_select_out == $past(clamp_w))
        else $error("profile not taken");
    profile_range_a: assert property (
        heater_profile_select_out <= 4'h9)
        else $error("profile out of range");
    run_gas_a: assert property (
        cfg_wr_w |=> run_gas_out == $past(wr_data_in[4]))
        else $error("gas enable not taken");
    write_ignored_a: assert property (
        wr_en_in && !cfg_wr_w |=> $stable(heater_profile_select_out)
            && $stable(run_gas_out))
        else $error("read-only write changed state");
    data_hold_a: assert property (
        !rd_en_in |=> $stable(rd_data_out))
        else $error("read data moved");
endmodule

bind env_sensor_result_status_regs result_regs_checker chk (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .cycle_done_in(cycle_done_in), .conv_active_in(conv_active_in),
    .rd_en_in(rd_en_in), .wr_en_in(wr_en_in), .wr_addr_in(wr_addr_in),
    .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out),
    .heater_profile_select_out(heater_profile_select_out),
    .run_gas_out(run_gas_out), .measuring_out(measuring_out),
    .new_data_out(new_data_out)
);

//--- testbench/env_sensor_result_status_regs_tb_top.sv
`timescale 1ns/100ps

module env_sensor_result_status_regs_tb_top;
    import env_sensor_pkg::*;

    // Engine side and host side signals
    logic clk_in, sys_rst_in, cycle_done_in, gas_real_in, heat_stable_in;
    logic conv_active_in, gas_active_in, rd_en_in, wr_en_in, read_burst_in;
    logic rd_valid_out, run_gas_out, measuring_out, new_data_out;
    raw20_t    press_raw_in, temp_raw_in;
    raw16_t    hum_raw_in;
    raw10_t    gas_raw_in;
    nibble_t   gas_range_in, gas_index_in, heater_profile_select_out;
    osrs_t     osrs_press_in, osrs_temp_in;
    reg_addr_t rd_addr_in, wr_addr_in;
    reg_byte_t wr_data_in, rd_data_out, got;
    int        fail_count, total_checks;
    // Low nibble byte per oversampling code
    reg_byte_t nib [8] = '{8'h00, 8'h00, 8'h80, 8'hc0,
                           8'he0, 8'hf0, 8'hf0, 8'hf0};

    env_sensor_result_status_regs uut (
        .clk_in, .sys_rst_in, .cycle_done_in, .press_raw_in, .temp_raw_in,
        .hum_raw_in, .gas_raw_in, .gas_range_in, .gas_real_in,
        .heat_stable_in, .gas_index_in, .conv_active_in, .gas_active_in,
        .osrs_press_in, .osrs_temp_in, .read_burst_in, .rd_en_in,
        .rd_addr_in, .wr_en_in, .wr_addr_in, .wr_data_in, .rd_data_out,
        .rd_valid_out, .heater_profile_select_out, .run_gas_out,
        .measuring_out, .new_data_out
    );

    host_port_model host (
        .clk_in, .measuring_in(measuring_out), .rd_valid_in(rd_valid_out),
        .rd_data_in(rd_data_out), .rd_en_out(rd_en_in),
        .rd_addr_out(rd_addr_in), .wr_en_out(wr_en_in),
        .wr_addr_out(wr_addr_in), .wr_data_out(wr_data_in),
        .burst_out(read_burst_in)
    );

    // ---------------------------------------------------
    // Helpers
    // ---------------------------------------------------
    task automatic check(input reg_byte_t seen, input reg_byte_t exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Read one byte and compare
    task automatic rx(input reg_addr_t a, input reg_byte_t e);
        host.read_reg(a, got);
        check(got, e);
    endtask

    // One full measurement cycle, results held by the caller
    task automatic run_cycle();
        conv_active_in = 1'b1;
        gas_active_in = 1'b1;
        repeat (3) @(negedge clk_in);
        cycle_done_in = 1'b1;
        conv_active_in = 1'b0;
        gas_active_in = 1'b0;
        @(negedge clk_in);
        cycle_done_in = 1'b0;
        repeat (2) @(negedge clk_in);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // 10 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        #(3000 * 100);
        fail_count++;
        stop_test();
    end

    // ---------------------------------------------------
    // Scenarios
    // ---------------------------------------------------
    initial begin
        {cycle_done_in, gas_real_in, heat_stable_in} = '0;
        {conv_active_in, gas_active_in, gas_index_in} = '0;
        {press_raw_in, temp_raw_in, hum_raw_in, gas_raw_in} = '0;
        {gas_range_in, osrs_press_in, osrs_temp_in} = '0;
        sys_rst_in = 1'b1;
        repeat (5) @(negedge clk_in);
        sys_rst_in = 1'b0;
        // Cleared bank, gaps included
        for (int a = 'h1d; a <= 'h2b; a++) rx(8'(a), 8'h00);
        rx(8'h71, 8'h00);
        host.write_reg(8'h71, 8'h1c);
        rx(8'h71, 8'h19);
        press_raw_in = 20'habcde;
        temp_raw_in = 20'h12345;
        hum_raw_in = 16'hbeef;
        gas_raw_in = 10'h2d7;
        gas_range_in = 4'ha;
        {gas_real_in, heat_stable_in} = 2'b11;
        gas_index_in = 4'h7;
        {osrs_press_in, osrs_temp_in} = {3'h5, 3'h5};
        conv_active_in = 1'b1;
        gas_active_in = 1'b1;
        repeat (2) @(negedge clk_in);
        rx(8'h1d, 8'h60);
        run_cycle();
        rx(8'h1d, 8'h87);
        rx(8'h1d, 8'h07);
        rx(8'h1f, 8'hab);
        rx(8'h20, 8'hcd);
        rx(8'h21, 8'he0);
        rx(8'h22, 8'h12);
        rx(8'h23, 8'h34);
        rx(8'h24, 8'h50);
        rx(8'h25, 8'hbe);
        rx(8'h26, 8'hef);
        rx(8'h2a, 8'hb5);
        rx(8'h2b, 8'hfa);
        // Every oversampling code, dummy and real slots, index clamp
        press_raw_in = 20'h0000f;
        temp_raw_in = 20'h0000f;
        for (int o = 0; o < 8; o++) begin
            {osrs_press_in, osrs_temp_in} = {3'(o), 3'(o)};
            gas_real_in = o[0];
            gas_index_in = 4'(8 + o);
            run_cycle();
            rx(8'h21, nib[o]);
            rx(8'h24, nib[o]);
            rx(8'h2b, {2'b11, o[0], 5'h1a});
            rx(8'h1d, (o == 0) ? 8'h88 : 8'h89);
        end
        // Frozen view during a serial read
        host.set_burst(1'b1);
        press_raw_in = 20'h12340;
        run_cycle();
        rx(8'h1f, 8'h00);
        host.set_burst(1'b0);
        repeat (2) @(negedge clk_in);
        rx(8'h1f, 8'h12);
        // Host writes to result and status bytes change nothing
        host.write_reg(8'h1f, 8'h55);
        host.write_reg(8'h1d, 8'hff);
        rx(8'h1f, 8'h12);
        rx(8'h1d, 8'h89);
        // Gas disabled: slot is a dummy
        host.write_reg(8'h71, 8'h05);
        rx(8'h71, 8'h05);
        run_cycle();
        rx(8'h2b, 8'hda);
        stop_test();
    end
endmodule
